/* logic/tfl_pkg.sv */
package tfl_pkg;
    // Channel order: 0 remote 1, 1 local, 2 remote 2
    localparam int NUM_CH = 3;
    localparam int NUM_OFS = 2;
    localparam int IDX_W = 8;
    localparam int WORD_LSB = 2;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int HYST_W = 4;
    // Temperatures in quarter degrees: 8 integer bits, 2 fraction bits
    localparam int FRAC_W = 2;
    localparam int TEMP_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_START [NUM_CH] = '{8'h67, 8'h68, 8'h69};
    localparam logic [IDX_W-1:0] IDX_CRIT [NUM_CH] = '{8'h6a, 8'h6b, 8'h6c};
    localparam logic [IDX_W-1:0] IDX_HYST_RL = 8'h6d;
    localparam logic [IDX_W-1:0] IDX_HYST_R2 = 8'h6e;
    localparam logic [IDX_W-1:0] IDX_TEST = 8'h6f;
    localparam logic [IDX_W-1:0] IDX_OFS [NUM_OFS] = '{8'h70, 8'h71};
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h80;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h81;
    localparam logic [IDX_W-1:0] IDX_NONE = 8'hff;

    // Reset values
    localparam logic [BYTE_W-1:0] START_RST = 8'h5a;
    localparam logic [BYTE_W-1:0] CRIT_RST = 8'h64;
    localparam logic [BYTE_W-1:0] HYST_RL_RST = 8'h44;
    localparam logic [BYTE_W-1:0] HYST_R2_RST = 8'h40;
    localparam logic [BYTE_W-1:0] OFS_RST = 8'h00;

    // Field layout
    localparam logic [BYTE_W-1:0] CRIT_OFF = 8'h80;
    localparam int TEST_BIT = 0;
    localparam int HYST_LO_LSB = 0;
    localparam int HYST_HI_LSB = 4;

    // Interrupt status layout: override entered per channel, fan start per channel
    localparam int EVT_W = 6;
    localparam int EVT_FULL_LSB = 0;
    localparam int EVT_RUN_LSB = 3;
endpackage : tfl_pkg

/* logic/tfl_chan.sv */
`timescale 1ns/100ps
module tfl_chan
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic temp_valid,
    input wire logic [tfl_pkg::TEMP_W-1:0] temp_raw,
    input wire logic [tfl_pkg::BYTE_W-1:0] offset,
    input wire logic [tfl_pkg::BYTE_W-1:0] start_thr,
    input wire logic [tfl_pkg::BYTE_W-1:0] crit_lim,
    input wire logic [tfl_pkg::HYST_W-1:0] hyst,
    output logic fan_run_reg,
    output logic full_duty_reg,
    output logic alarm_reg
);
    localparam int CW = tfl_pkg::TEMP_W + 2;
    logic signed [CW-1:0] sum_next;
    logic [tfl_pkg::TEMP_W-1:0] corr_reg;
    logic valid_d_reg;
    logic signed [CW-1:0] corr_s;
    logic signed [CW-1:0] start_q;
    logic signed [CW-1:0] crit_q;
    logic signed [CW-1:0] hyst_q;
    logic crit_en;

    // Offset in half degrees becomes two quarter steps, sign extended
    assign sum_next = $signed({2'h0, temp_raw}) + $signed({{(CW-9){offset[7]}}, offset, 1'h0}); // R13
    // Limits and hysteresis scaled to quarter degrees, one degree per code
    assign corr_s = $signed({2'h0, corr_reg}); // R14
    assign start_q = $signed({2'h0, start_thr, 2'h0});
    assign crit_q = $signed({2'h0, crit_lim, 2'h0});
    assign hyst_q = $signed({{(CW-tfl_pkg::HYST_W-tfl_pkg::FRAC_W){1'b0}}, hyst, 2'h0}); // R14
    assign crit_en = (crit_lim != tfl_pkg::CRIT_OFF); // R4

    // Corrected reading, saturated to the reading range
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            corr_reg <= '0;
            valid_d_reg <= 1'b0;
        end
        else
        begin
            valid_d_reg <= temp_valid;
            if (temp_valid)
            begin
                if (sum_next[CW-1])
                    corr_reg <= '0;
                else if (sum_next[CW-2:tfl_pkg::TEMP_W] != '0)
                    corr_reg <= '1;
                else
                    corr_reg <= sum_next[tfl_pkg::TEMP_W-1:0]; // R13
            end
        end
    end

    // Fan start with hysteresis below the start threshold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fan_run_reg <= 1'b0;
        else if (valid_d_reg)
        begin
            if (corr_s > start_q)
                fan_run_reg <= 1'b1; // R1
            else if (corr_s <= start_q - hyst_q)
                fan_run_reg <= 1'b0; // R8
        end
    end

    // Critical override latch and alarm comparator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            full_duty_reg <= 1'b0;
            alarm_reg <= 1'b0;
        end
        else if (!crit_en)
        begin
            full_duty_reg <= 1'b0; // R4
            alarm_reg <= 1'b0;
        end
        else if (valid_d_reg)
        begin
            alarm_reg <= (corr_s > crit_q); // R6
            if (corr_s > crit_q)
                full_duty_reg <= 1'b1; // R3
            else if (corr_s < crit_q - hyst_q)
                full_duty_reg <= 1'b0; // R5
        end
    end

    property p_fan_start;
        @(posedge pclk) disable iff (!presetn) valid_d_reg && (corr_s > start_q) |=> fan_run_reg;
    endproperty
    a_fan_start: assert property (p_fan_start) else $error("fan did not start above threshold"); // R1

    property p_fan_hold;
        @(posedge pclk) disable iff (!presetn)
            fan_run_reg && !(valid_d_reg && (corr_s <= start_q - hyst_q)) |=> fan_run_reg;
    endproperty
    a_fan_hold: assert property (p_fan_hold) else $error("fan stopped inside hysteresis band"); // R8

    property p_full_hold;
        @(posedge pclk) disable iff (!presetn)
            crit_en && full_duty_reg && !(valid_d_reg && (corr_s < crit_q - hyst_q)) |=> full_duty_reg;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("override released above limit minus hysteresis"); // R5

    property p_crit_off;
        @(posedge pclk) disable iff (!presetn) (crit_lim == tfl_pkg::CRIT_OFF) |=> !full_duty_reg && !alarm_reg;
    endproperty
    a_crit_off: assert property (p_crit_off) else $error("override active with limit disabled"); // R4

    property p_offset_zero;
        @(posedge pclk) disable iff (!presetn) temp_valid && (offset == '0) |=> corr_reg == $past(temp_raw);
    endproperty
    a_offset_zero: assert property (p_offset_zero) else $error("zero offset changed the reading"); // R13
endmodule : tfl_chan

/* logic/tfl_xnor_tree.sv */
`timescale 1ns/100ps
module tfl_xnor_tree
#(
    parameter int N = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [N-1:0] pins,
    output logic tree_out_reg
);
    logic [N-1:0] stage;

    // Chain of exclusive-NOR gates across the test pins
    assign stage[0] = pins[0];
    generate
        for (genvar i = 1; i < N; i++)
        begin : g_stage
            assign stage[i] = ~(stage[i-1] ^ pins[i]);
        end
    endgenerate

    // Tree result is registered and held low outside test mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tree_out_reg <= 1'b0;
        else
            tree_out_reg <= enable & stage[N-1];
    end
endmodule : tfl_xnor_tree

/* logic/tfl_limit_regs.sv */
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
// Function
// (R1) Fan runs once reading exceeds start threshold
// (R2) Thresholds reset 0x5a, critical limits 0x64
// (R3) Critical overtemperature forces all fans full
// (R4) Critical limit 0x80 disables the override
// (R5) Override holds until below limit minus hysteresis
// (R6) Alarm pin driven low when over limit
// (R7) Three 4-bit hysteresis fields, fixed positions
// (R8) Fan keeps running down to threshold minus hysteresis
// (R9) Software keeps hysteresis at four or more
// (R10) Lock bit discards writes to these registers
// (R11) Test bit selects the pin tree mode
// (R12) Software leaves upper test bits unwritten
// (R13) Signed half-degree offset added to readings; remote 2 has no offset register here, its offset is tied to zero
// (R14) Comparisons use corrected reading, degree hysteresis
module tfl_limit_regs
#(
    parameter int ADDR_W = 12,
    parameter int TEST_PINS = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tfl_pkg::DATA_W-1:0] pwdata,
    output logic [tfl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic temp_valid,
    input wire logic [tfl_pkg::TEMP_W-1:0] remote1_temp,
    input wire logic [tfl_pkg::TEMP_W-1:0] local_temp,
    input wire logic [tfl_pkg::TEMP_W-1:0] remote2_temp,
    input wire logic cfg_lock,
    input wire logic critical_thermal_alarm_pin_output_mode,
    input wire logic [TEST_PINS-1:0] test_pins,
    output logic [tfl_pkg::NUM_CH-1:0] fan_min_duty_run,
    output logic fan_full_duty,
    output logic critical_thermal_alarm_out,
    output logic critical_thermal_alarm_oe,
    output logic pin_tree_test_mode,
    output logic xnor_tree_out,
    output logic irq
);
    logic [tfl_pkg::BYTE_W-1:0] start_thr_reg [tfl_pkg::NUM_CH];
    logic [tfl_pkg::BYTE_W-1:0] crit_lim_reg [tfl_pkg::NUM_CH];
    logic [tfl_pkg::BYTE_W-1:0] ofs_reg [tfl_pkg::NUM_OFS];
    logic [tfl_pkg::BYTE_W-1:0] hyst_rl_reg;
    logic [tfl_pkg::BYTE_W-1:0] hyst_r2_reg;
    logic test_en_reg;
    logic [tfl_pkg::EVT_W-1:0] irq_stat_reg;
    logic [tfl_pkg::EVT_W-1:0] irq_mask_reg;
    logic [tfl_pkg::NUM_CH-1:0] full_prev_reg;
    logic [tfl_pkg::NUM_CH-1:0] run_prev_reg;
    logic [tfl_pkg::NUM_CH-1:0] ch_full;
    logic [tfl_pkg::NUM_CH-1:0] ch_alarm;
    logic [tfl_pkg::TEMP_W-1:0] ch_temp [tfl_pkg::NUM_CH];
    logic [tfl_pkg::BYTE_W-1:0] ch_ofs [tfl_pkg::NUM_CH];
    logic [tfl_pkg::HYST_W-1:0] ch_hyst [tfl_pkg::NUM_CH];
    logic [tfl_pkg::EVT_W-1:0] evt;
    logic [tfl_pkg::EVT_W-1:0] irq_clr;
    logic [tfl_pkg::IDX_W-1:0] acc_idx;
    logic [tfl_pkg::BYTE_W-1:0] rd_byte;
    logic rd_hit;
    logic access;
    logic wr_fire;
    logic cfg_wr;

    // Word index of an aligned mapped address, or the no-register code
    function automatic logic [tfl_pkg::IDX_W-1:0] word_of(input logic [ADDR_W-1:0] a);
        logic [tfl_pkg::IDX_W-1:0] idx;
        idx = tfl_pkg::IDX_NONE;
        if ((a[tfl_pkg::WORD_LSB-1:0] == '0) && (a[ADDR_W-1:tfl_pkg::IDX_W+tfl_pkg::WORD_LSB] == '0))
            idx = a[tfl_pkg::IDX_W+tfl_pkg::WORD_LSB-1:tfl_pkg::WORD_LSB];
        return idx;
    endfunction : word_of

    // APB handshake: one wait state, write takes effect at the completing edge
    assign access = psel & penable;
    assign acc_idx = word_of(paddr);
    assign wr_fire = access & pready & pwrite;
    assign cfg_wr = wr_fire & ~cfg_lock; // R10

    // Ready, read data and error are loaded in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access & ~pready;
            if (access & ~pready)
            begin
                prdata <= {{(tfl_pkg::DATA_W-tfl_pkg::BYTE_W){1'b0}}, rd_byte};
                pslverr <= ~rd_hit;
            end
        end
    end

    // Read multiplexer; unused bits read as zero
    always_comb
    begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        if (acc_idx == tfl_pkg::IDX_HYST_RL)
            rd_byte = hyst_rl_reg;
        else if (acc_idx == tfl_pkg::IDX_HYST_R2)
            rd_byte = hyst_r2_reg;
        else if (acc_idx == tfl_pkg::IDX_TEST)
            rd_byte[tfl_pkg::TEST_BIT] = test_en_reg;
        else if (acc_idx == tfl_pkg::IDX_IRQ_STAT)
            rd_byte[tfl_pkg::EVT_W-1:0] = irq_stat_reg;
        else if (acc_idx == tfl_pkg::IDX_IRQ_MASK)
            rd_byte[tfl_pkg::EVT_W-1:0] = irq_mask_reg;
        else if (acc_idx == tfl_pkg::IDX_OFS[0])
            rd_byte = ofs_reg[0];
        else if (acc_idx == tfl_pkg::IDX_OFS[1])
            rd_byte = ofs_reg[1];
        else
            rd_hit = 1'b0;
        for (int i = 0; i < tfl_pkg::NUM_CH; i++)
        begin
            if (acc_idx == tfl_pkg::IDX_START[i])
            begin
                rd_byte = start_thr_reg[i];
                rd_hit = 1'b1;
            end
            if (acc_idx == tfl_pkg::IDX_CRIT[i])
            begin
                rd_byte = crit_lim_reg[i];
                rd_hit = 1'b1;
            end
        end
    end

    // Per-channel thresholds and critical limits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < tfl_pkg::NUM_CH; i++)
            begin
                start_thr_reg[i] <= tfl_pkg::START_RST; // R2
                crit_lim_reg[i] <= tfl_pkg::CRIT_RST; // R2
            end
        end
        else if (cfg_wr)
        begin
            for (int i = 0; i < tfl_pkg::NUM_CH; i++)
            begin
                if (acc_idx == tfl_pkg::IDX_START[i])
                    start_thr_reg[i] <= pwdata[tfl_pkg::BYTE_W-1:0]; // R10
                if (acc_idx == tfl_pkg::IDX_CRIT[i])
                    crit_lim_reg[i] <= pwdata[tfl_pkg::BYTE_W-1:0]; // R10
            end
        end
    end

    // Hysteresis, reading offsets and test enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hyst_rl_reg <= tfl_pkg::HYST_RL_RST;
            hyst_r2_reg <= tfl_pkg::HYST_R2_RST;
            test_en_reg <= 1'b0;
            for (int i = 0; i < tfl_pkg::NUM_OFS; i++)
                ofs_reg[i] <= tfl_pkg::OFS_RST;
        end
        else if (cfg_wr)
        begin
            if (acc_idx == tfl_pkg::IDX_HYST_RL)
                hyst_rl_reg <= pwdata[tfl_pkg::BYTE_W-1:0];
            if (acc_idx == tfl_pkg::IDX_HYST_R2)
                hyst_r2_reg <= pwdata[tfl_pkg::BYTE_W-1:0];
            // Only the enable bit is kept; upper bits are not for software
            if (acc_idx == tfl_pkg::IDX_TEST)
                test_en_reg <= pwdata[tfl_pkg::TEST_BIT]; // R11 R12
            for (int i = 0; i < tfl_pkg::NUM_OFS; i++)
                if (acc_idx == tfl_pkg::IDX_OFS[i])
                    ofs_reg[i] <= pwdata[tfl_pkg::BYTE_W-1:0];
        end
    end

    // Channel inputs: hysteresis fields and offsets per channel
    assign ch_temp[0] = remote1_temp;
    assign ch_temp[1] = local_temp;
    assign ch_temp[2] = remote2_temp;
    assign ch_hyst[0] = hyst_rl_reg[tfl_pkg::HYST_HI_LSB +: tfl_pkg::HYST_W]; // R7
    assign ch_hyst[1] = hyst_rl_reg[tfl_pkg::HYST_LO_LSB +: tfl_pkg::HYST_W]; // R7
    assign ch_hyst[2] = hyst_r2_reg[tfl_pkg::HYST_HI_LSB +: tfl_pkg::HYST_W]; // R7
    assign ch_ofs[0] = ofs_reg[0]; // R13
    assign ch_ofs[1] = ofs_reg[1]; // R13
    assign ch_ofs[2] = tfl_pkg::OFS_RST;

    // One comparator per temperature channel
    generate
        for (genvar g = 0; g < tfl_pkg::NUM_CH; g++)
        begin : g_ch
            tfl_chan u_ch
            (
                .pclk (pclk),
                .presetn (presetn),
                .temp_valid (temp_valid),
                .temp_raw (ch_temp[g]),
                .offset (ch_ofs[g]),
                .start_thr (start_thr_reg[g]),
                .crit_lim (crit_lim_reg[g]),
                .hyst (ch_hyst[g]),
                .fan_run_reg (fan_min_duty_run[g]),
                .full_duty_reg (ch_full[g]),
                .alarm_reg (ch_alarm[g])
            );
        end
    endgenerate

    // Fail-safe drive and open-drain alarm pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fan_full_duty <= 1'b0;
            critical_thermal_alarm_out <= 1'b0;
            critical_thermal_alarm_oe <= 1'b0;
        end
        else
        begin
            fan_full_duty <= |ch_full; // R3
            critical_thermal_alarm_out <= 1'b0;
            critical_thermal_alarm_oe <= critical_thermal_alarm_pin_output_mode & (|ch_alarm); // R6
        end
    end

    // Pin tree test mode
    assign pin_tree_test_mode = test_en_reg; // R11

    tfl_xnor_tree #(.N (TEST_PINS)) u_tree
    (
        .pclk (pclk),
        .presetn (presetn),
        .enable (test_en_reg),
        .pins (test_pins),
        .tree_out_reg (xnor_tree_out)
    );

    // Events: override entered and fan started, rising edges per channel
    assign evt[tfl_pkg::EVT_FULL_LSB +: tfl_pkg::NUM_CH] = ch_full & ~full_prev_reg;
    assign evt[tfl_pkg::EVT_RUN_LSB +: tfl_pkg::NUM_CH] = fan_min_duty_run & ~run_prev_reg;
    assign irq_clr = (wr_fire && (acc_idx == tfl_pkg::IDX_IRQ_STAT)) ? pwdata[tfl_pkg::EVT_W-1:0] : '0;

    // Sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            full_prev_reg <= '0;
            run_prev_reg <= '0;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq <= 1'b0;
        end
        else
        begin
            full_prev_reg <= ch_full;
            run_prev_reg <= fan_min_duty_run;
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | evt;
            if (wr_fire && (acc_idx == tfl_pkg::IDX_IRQ_MASK))
                irq_mask_reg <= pwdata[tfl_pkg::EVT_W-1:0];
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    property p_reset_values;
        @(posedge pclk) disable iff (!presetn) !$past(presetn) |->
            (start_thr_reg[0] == tfl_pkg::START_RST) && (start_thr_reg[2] == tfl_pkg::START_RST) &&
            (crit_lim_reg[1] == tfl_pkg::CRIT_RST) && (crit_lim_reg[2] == tfl_pkg::CRIT_RST);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("wrong threshold or limit after reset"); // R2

    property p_lock;
        @(posedge pclk) disable iff (!presetn) wr_fire && cfg_lock |=>
            $stable(start_thr_reg[1]) && $stable(crit_lim_reg[0]) && $stable(hyst_rl_reg) &&
            $stable(ofs_reg[0]) && $stable(test_en_reg);
    endproperty
    a_lock: assert property (p_lock) else $error("locked register was written"); // R10

    property p_full_all;
        @(posedge pclk) disable iff (!presetn) (|ch_full) |=> fan_full_duty;
    endproperty
    a_full_all: assert property (p_full_all) else $error("fans not forced to full duty"); // R3

    property p_alarm_pin;
        @(posedge pclk) disable iff (!presetn) critical_thermal_alarm_oe |->
            $past(critical_thermal_alarm_pin_output_mode) && $past(|ch_alarm) && !critical_thermal_alarm_out;
    endproperty
    a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin driven without cause"); // R6

    sequence s_test_set;
        cfg_wr && (acc_idx == tfl_pkg::IDX_TEST) && pwdata[tfl_pkg::TEST_BIT];
    endsequence
    property p_test_mode;
        @(posedge pclk) disable iff (!presetn) s_test_set |=> pin_tree_test_mode;
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("test mode not entered"); // R11

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    property p_apb_wait;
        @(posedge pclk) disable iff (!presetn) s_setup ##1 access |-> s_answer;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("ready not one wait state after setup");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn) (|(irq_stat_reg & irq_mask_reg)) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("unmasked status did not raise interrupt");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn) (|(evt & irq_clr)) |=> (|irq_stat_reg);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");
endmodule : tfl_limit_regs

/* bench/tfl_host.sv */
`timescale 1ns/100ps
// Host model: APB master issuing one transfer at a time
module tfl_host
(
    input wire logic pclk,
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [tfl_pkg::DATA_W-1:0] pwdata,
    input wire logic [tfl_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle from time zero
    initial
    begin
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = '0;
    end

    // Setup, then access held until pready; released address and data are inverted so stale values never pass
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : tfl_host

/* bench/thermal_fan_limit_registers_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module thermal_fan_limit_registers_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, temp_valid, cfg_lock, critical_thermal_alarm_pin_output_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] remote1_temp, local_temp, remote2_temp;
    logic [7:0] test_pins;
    logic [2:0] fan_min_duty_run;
    logic fan_full_duty, critical_thermal_alarm_out, critical_thermal_alarm_oe, pin_tree_test_mode, xnor_tree_out, irq;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    tfl_host i_host (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
    tfl_limit_regs i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .temp_valid, .remote1_temp, .local_temp, .remote2_temp, .cfg_lock, .critical_thermal_alarm_pin_output_mode, .test_pins,
        .fan_min_duty_run, .fan_full_duty, .critical_thermal_alarm_out, .critical_thermal_alarm_oe,
        .pin_tree_test_mode, .xnor_tree_out, .irq);

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic e;
        i_host.xfer(1'b1, ba(idx), {24'h0, d}, rd, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic e;
        i_host.xfer(1'b0, ba(idx), 32'h0, rd, e);
        `CHK("slverr", exp_err, e)
        if (!exp_err)
            `CHK("rdata", exp, rd)
    endtask : rd_chk

    // One reading pulse, then time for every decision to land
    task automatic reading(input logic [9:0] r1, input logic [9:0] lo, input logic [9:0] r2);
        @(posedge pclk);
        temp_valid <= 1'b1;
        remote1_temp <= r1;
        local_temp <= lo;
        remote2_temp <= r2;
        @(posedge pclk);
        temp_valid <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : reading

    task automatic t_regs();
        for (int i = 0; i < 3; i++)
        begin
            rd_chk(tfl_pkg::IDX_START[i], 32'h0000005a, 1'b0);
            rd_chk(tfl_pkg::IDX_CRIT[i], 32'h00000064, 1'b0);
        end
        rd_chk(tfl_pkg::IDX_HYST_RL, 32'h00000044, 1'b0);
        rd_chk(tfl_pkg::IDX_HYST_R2, 32'h00000040, 1'b0);
        rd_chk(tfl_pkg::IDX_OFS[0], 32'h00000000, 1'b0);
        rd_chk(tfl_pkg::IDX_OFS[1], 32'h00000000, 1'b0);
        rd_chk(tfl_pkg::IDX_NONE, 32'h0, 1'b1);
        wr(tfl_pkg::IDX_HYST_RL, 8'h95);
        rd_chk(tfl_pkg::IDX_HYST_RL, 32'h00000095, 1'b0);
    endtask : t_regs

    task automatic t_test();
        rd_chk(tfl_pkg::IDX_TEST, 32'h00000000, 1'b0);
        wr(tfl_pkg::IDX_TEST, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK("test mode", 1'b1, pin_tree_test_mode)
        // Pins 0x5c hold an even count of ones; seven stages invert that parity
        `CHK("tree out", 1'b1, xnor_tree_out)
        wr(tfl_pkg::IDX_TEST, 8'h00);
        repeat (3) @(posedge pclk);
        `CHK("test mode", 1'b0, pin_tree_test_mode)
        `CHK("tree out", 1'b0, xnor_tree_out)
    endtask : t_test

    task automatic t_lock();
        cfg_lock <= 1'b1;
        wr(tfl_pkg::IDX_START[0], 8'h33);
        rd_chk(tfl_pkg::IDX_START[0], 32'h0000005a, 1'b0);
        cfg_lock <= 1'b0;
        wr(tfl_pkg::IDX_START[0], 8'h33);
        rd_chk(tfl_pkg::IDX_START[0], 32'h00000033, 1'b0);
    endtask : t_lock

    // Local channel: threshold 360 quarters, hysteresis 5 degrees, offset +2 then -2 degrees
    task automatic t_fan();
        wr(tfl_pkg::IDX_OFS[1], 8'h04);
        reading(10'd0, 10'd353, 10'd0);
        `CHK("fan run", 3'b010, fan_min_duty_run)
        reading(10'd0, 10'd333, 10'd0);
        `CHK("fan run", 3'b010, fan_min_duty_run)
        reading(10'd0, 10'd332, 10'd0);
        `CHK("fan run", 3'b000, fan_min_duty_run)
        wr(tfl_pkg::IDX_OFS[1], 8'hfc);
        reading(10'd0, 10'd368, 10'd0);
        `CHK("fan run", 3'b000, fan_min_duty_run)
        reading(10'd0, 10'd369, 10'd0);
        `CHK("fan run", 3'b010, fan_min_duty_run)
        reading(10'd0, 10'd0, 10'd0);
    endtask : t_fan

    // Remote 2: limit 400 quarters, hysteresis 4 degrees
    task automatic t_crit();
        wr(tfl_pkg::IDX_IRQ_MASK, 8'h00);
        wr(tfl_pkg::IDX_IRQ_STAT, 8'h3f);
        reading(10'd0, 10'd0, 10'd401);
        `CHK("full duty", 1'b1, fan_full_duty)
        `CHK("alarm oe", 1'b1, critical_thermal_alarm_oe)
        `CHK("irq", 1'b0, irq)
        rd_chk(tfl_pkg::IDX_IRQ_STAT, 32'h00000024, 1'b0);
        wr(tfl_pkg::IDX_IRQ_MASK, 8'h3f);
        repeat (3) @(posedge pclk);
        `CHK("irq", 1'b1, irq)
        wr(tfl_pkg::IDX_IRQ_STAT, 8'h3f);
        repeat (3) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        reading(10'd0, 10'd0, 10'd400);
        `CHK("alarm oe", 1'b0, critical_thermal_alarm_oe)
        `CHK("full duty", 1'b1, fan_full_duty)
        reading(10'd0, 10'd0, 10'd384);
        `CHK("full duty", 1'b1, fan_full_duty)
        reading(10'd0, 10'd0, 10'd383);
        `CHK("full duty", 1'b0, fan_full_duty)
        reading(10'd0, 10'd0, 10'd401);
        `CHK("full duty", 1'b1, fan_full_duty)
        // Alarm pin stays released while it is not configured as an output
        critical_thermal_alarm_pin_output_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("alarm oe", 1'b0, critical_thermal_alarm_oe)
        critical_thermal_alarm_pin_output_mode <= 1'b1;
        wr(tfl_pkg::IDX_CRIT[2], 8'h80);
        repeat (3) @(posedge pclk);
        `CHK("full duty", 1'b0, fan_full_duty)
        `CHK("alarm oe", 1'b0, critical_thermal_alarm_oe)
        `CHK("alarm out", 1'b0, critical_thermal_alarm_out)
    endtask : t_crit

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        temp_valid = 1'b0;
        remote1_temp = '0;
        local_temp = '0;
        remote2_temp = '0;
        cfg_lock = 1'b0;
        critical_thermal_alarm_pin_output_mode = 1'b1;
        test_pins = 8'h5c;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_test();
        t_lock();
        t_fan();
        t_crit();
        give_verdict();
    end
endmodule : thermal_fan_limit_registers_tb
